// file: core_bitops_pkg.sv
// constants shared by the bit and transfer execution unit
// assumes a 32-bit Avalon-MM register bus with byte addresses
package core_bitops_pkg;

	// register offsets (byte addresses)
	localparam logic [5:0] OFS_COMMAND     = 6'h00;
	localparam logic [5:0] OFS_STATUS_REG  = 6'h04;
	localparam logic [5:0] OFS_ACCESS_ADDR = 6'h08;
	localparam logic [5:0] OFS_ACCESS_DATA = 6'h0C;
	localparam logic [5:0] OFS_Z_POINTER   = 6'h10;
	localparam logic [5:0] OFS_STACK_PTR   = 6'h14;
	localparam logic [5:0] OFS_EXEC_INFO   = 6'h18;

	// command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_REG_LSB  = 8;
	localparam int CMD_BIT_LSB  = 16;
	localparam int CMD_IO_LSB   = 24;

	// access address fields: space in [9:8], index in [7:0]
	localparam int ACC_SPACE_LSB = 8;
	localparam logic [1:0] SPACE_GPR = 2'h0;
	localparam logic [1:0] SPACE_IO  = 2'h1;
	localparam logic [1:0] SPACE_RAM = 2'h2;

	// status register flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// operation codes
	localparam logic [4:0] OP_NOP                  = 5'h00;
	localparam logic [4:0] OP_IO_READ              = 5'h01;
	localparam logic [4:0] OP_IO_WRITE             = 5'h02;
	localparam logic [4:0] OP_PUSH                 = 5'h03;
	localparam logic [4:0] OP_POP                  = 5'h04;
	localparam logic [4:0] OP_ATOMIC_EXCHANGE      = 5'h05;
	localparam logic [4:0] OP_ATOMIC_LOAD_OR       = 5'h06;
	localparam logic [4:0] OP_ATOMIC_LOAD_ANDNOT   = 5'h07;
	localparam logic [4:0] OP_ATOMIC_LOAD_XOR      = 5'h08;
	localparam logic [4:0] OP_SHIFT_UP_LOGICAL     = 5'h09;
	localparam logic [4:0] OP_SHIFT_DOWN_LOGICAL   = 5'h0A;
	localparam logic [4:0] OP_ROTATE_UP_CARRY      = 5'h0B;
	localparam logic [4:0] OP_ROTATE_DOWN_CARRY    = 5'h0C;
	localparam logic [4:0] OP_SHIFT_DOWN_SIGNED    = 5'h0D;
	localparam logic [4:0] OP_NIBBLE_SWAP          = 5'h0E;
	localparam logic [4:0] OP_STATUS_FLAG_ONE      = 5'h0F;
	localparam logic [4:0] OP_STATUS_FLAG_ZERO     = 5'h10;
	localparam logic [4:0] OP_IO_BIT_ONE           = 5'h11;
	localparam logic [4:0] OP_IO_BIT_ZERO          = 5'h12;
	localparam logic [4:0] OP_REG_BIT_TO_T         = 5'h13;
	localparam logic [4:0] OP_T_TO_REG_BIT         = 5'h14;

	// listed cycle counts
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [2:0] CYC_TWO   = 3'h2;
	// extra cycle for internal SRAM data accesses
	localparam logic [2:0] CYC_SRAM_EXTRA = 3'h1;

	localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage

// file: core_bitops.sv
// bit, shift and transfer execution unit with its own registers, I/O space and SRAM
// assumes an Avalon-MM master on the clock domain; one command runs at a time
//
// Function
// RL1: register/I/O transfers, one cycle, flags kept
// RL2: push writes register to stack, one cycle
// RL3: pop loads register from stack, two cycles
// RL4: exchange and load-or-write at Z, two cycles
// RL5: load-andnot-write at Z, two cycles, no flags
// RL6: load-xor-write at Z, two cycles
// RL7: up shift/rotate: bit7 to carry, ZCNVH updated
// RL8: down shifts: bit0 to carry, ZCNV updated
// RL9: I/O bit force one/zero in one cycle
// RL10: register bit copied into T, one cycle
// RL11: T copied into register bit, one cycle
// RL12: overflow flag force one/zero, one cycle
// RL13: half-carry force one/zero, one cycle
// RL14: any status flag force one/zero, one cycle
// RL15: internal SRAM access adds one cycle
// RL16: counts hold for internal memory only
// RL17: other operations leave status register untouched
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module core_bitops #(
	parameter int RAM_DEPTH = 256,
	parameter int NUM_GPR   = 32,
	parameter int NUM_IO    = 64
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             busy,
	output logic      [7:0]  status_register
);

	localparam int RAW = $clog2(RAM_DEPTH);
	localparam int GAW = $clog2(NUM_GPR);
	localparam int IAW = $clog2(NUM_IO);
	localparam logic [15:0] SP_RESET = 16'(RAM_DEPTH - 1);

	typedef enum logic [0:0] {
		st_idle,
		st_run
	} st_e;

	typedef struct packed {
		st_e                         st;
		logic [4:0]                  op;
		logic [4:0]                  rsel;
		logic [2:0]                  bsel;
		logic [5:0]                  asel;
		logic [2:0]                  cnt;
		logic [2:0]                  last_cycles;
		logic [7:0]                  flags;
		logic [15:0]                 zptr;
		logic [15:0]                 sptr;
		logic [9:0]                  acc_addr;
		logic                        ack;
		logic                        wreq;
		logic                        run;
		logic [31:0]                 rdata;
		logic [NUM_GPR-1:0][7:0]     gpr;
		logic [NUM_IO-1:0][7:0]      io;
		logic [RAM_DEPTH-1:0][7:0]   ram;
	} state_s;

	state_s r;
	state_s next_r;

	// total cycles an operation occupies the unit
	function automatic logic [2:0] op_cycles(input logic [4:0] op);
		logic [2:0] n;
		n = core_bitops_pkg::CYC_ONE;
		case (op)
			core_bitops_pkg::OP_PUSH:
				n = core_bitops_pkg::CYC_ONE + core_bitops_pkg::CYC_SRAM_EXTRA; // RL2 RL15 RL16
			core_bitops_pkg::OP_POP:
				n = core_bitops_pkg::CYC_TWO + core_bitops_pkg::CYC_SRAM_EXTRA; // RL3 RL15 RL16
			core_bitops_pkg::OP_ATOMIC_EXCHANGE,
			core_bitops_pkg::OP_ATOMIC_LOAD_OR,
			core_bitops_pkg::OP_ATOMIC_LOAD_ANDNOT,
			core_bitops_pkg::OP_ATOMIC_LOAD_XOR:
				n = core_bitops_pkg::CYC_TWO + core_bitops_pkg::CYC_SRAM_EXTRA; // RL4 RL5 RL6 RL15
			default:
				n = core_bitops_pkg::CYC_ONE;
		endcase
		return n;
	endfunction

	// byte-lane merge of a 32-bit write into an existing word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// one-hot select of the location space named by the access address
	function automatic logic [2:0] space_sel(input logic [1:0] space);
		logic [2:0] s;
		s = 3'h0;
		case (space)
			core_bitops_pkg::SPACE_GPR: s = 3'h1;
			core_bitops_pkg::SPACE_IO:  s = 3'h2;
			core_bitops_pkg::SPACE_RAM: s = 3'h4;
			default:                    s = 3'h0;
		endcase
		return s;
	endfunction

	logic [7:0]     d_reg;
	logic [7:0]     d_ram;
	logic [7:0]     d_sh;
	logic           sh_c;
	logic [RAW-1:0] z_idx;
	logic [RAW-1:0] pop_idx;
	logic [31:0]    rd_word;
	logic [31:0]    wr_word;
	logic           take;
	logic [7:0]     acc_idx;
	logic [2:0]     acc_sel;

	always_comb begin
		next_r  = r;
		d_reg   = r.gpr[r.rsel[GAW-1:0]];
		z_idx   = r.zptr[RAW-1:0];
		pop_idx = RAW'(r.sptr + 16'h0001);
		d_ram   = r.ram[z_idx];
		d_sh    = 8'h00;
		sh_c    = 1'b0;
		acc_idx = r.acc_addr[7:0];
		acc_sel = space_sel(r.acc_addr[9:8]);
		rd_word = 32'h0000_0000;
		wr_word = 32'h0000_0000;
		// requests are only answered while no command runs
		take    = (read || write) && !r.ack && r.st == st_idle;

		// register bus: registered waitrequest, one-cycle acknowledge
		next_r.ack = take;
		if (r.ack && write) begin
			case (address)
				core_bitops_pkg::OFS_COMMAND: begin
					wr_word = lane_merge(32'h0000_0000, writedata, byteenable);
					next_r.op   = wr_word[core_bitops_pkg::CMD_OP_LSB +: 5];
					next_r.rsel = wr_word[core_bitops_pkg::CMD_REG_LSB +: 5];
					next_r.bsel = wr_word[core_bitops_pkg::CMD_BIT_LSB +: 3];
					next_r.asel = wr_word[core_bitops_pkg::CMD_IO_LSB +: 6];
					next_r.cnt  = op_cycles(wr_word[4:0]) - 3'h1;
					next_r.last_cycles = op_cycles(wr_word[4:0]);
					next_r.st   = st_run;
				end
				core_bitops_pkg::OFS_STATUS_REG: begin
					if (byteenable[0]) begin
						next_r.flags = writedata[7:0];
					end
				end
				core_bitops_pkg::OFS_ACCESS_ADDR: begin
					wr_word = lane_merge({22'h000000, r.acc_addr}, writedata, byteenable);
					next_r.acc_addr = wr_word[9:0];
				end
				core_bitops_pkg::OFS_ACCESS_DATA: begin
					if (byteenable[0] && acc_sel[0]) begin
						next_r.gpr[acc_idx[GAW-1:0]] = writedata[7:0];
					end
					if (byteenable[0] && acc_sel[1]) begin
						next_r.io[acc_idx[IAW-1:0]] = writedata[7:0];
					end
					if (byteenable[0] && acc_sel[2]) begin
						next_r.ram[acc_idx[RAW-1:0]] = writedata[7:0];
					end
				end
				core_bitops_pkg::OFS_Z_POINTER: begin
					wr_word = lane_merge({16'h0000, r.zptr}, writedata, byteenable);
					next_r.zptr = wr_word[15:0];
				end
				core_bitops_pkg::OFS_STACK_PTR: begin
					wr_word = lane_merge({16'h0000, r.sptr}, writedata, byteenable);
					next_r.sptr = wr_word[15:0];
				end
				default: ;
			endcase
		end
		if (take && read) begin
			case (address)
				core_bitops_pkg::OFS_COMMAND:
					rd_word = {2'h0, r.asel, 5'h00, r.bsel, 3'h0, r.rsel, 3'h0, r.op};
				core_bitops_pkg::OFS_STATUS_REG:
					rd_word = {24'h000000, r.flags};
				core_bitops_pkg::OFS_ACCESS_ADDR:
					rd_word = {22'h000000, r.acc_addr};
				core_bitops_pkg::OFS_ACCESS_DATA: begin
					if (acc_sel[0]) begin
						rd_word = {24'h000000, r.gpr[acc_idx[GAW-1:0]]};
					end else if (acc_sel[1]) begin
						rd_word = {24'h000000, r.io[acc_idx[IAW-1:0]]};
					end else if (acc_sel[2]) begin
						rd_word = {24'h000000, r.ram[acc_idx[RAW-1:0]]};
					end
				end
				core_bitops_pkg::OFS_Z_POINTER:
					rd_word = {16'h0000, r.zptr};
				core_bitops_pkg::OFS_STACK_PTR:
					rd_word = {16'h0000, r.sptr};
				core_bitops_pkg::OFS_EXEC_INFO:
					rd_word = {28'h0000000, r.last_cycles, r.st == st_run};
				default:
					rd_word = 32'h0000_0000;
			endcase
			next_r.rdata = rd_word;
		end

		// shifter shared by the five shift and rotate operations
		case (r.op)
			core_bitops_pkg::OP_SHIFT_UP_LOGICAL: begin
				d_sh = {d_reg[6:0], 1'b0}; // RL7
				sh_c = d_reg[7];
			end
			core_bitops_pkg::OP_ROTATE_UP_CARRY: begin
				d_sh = {d_reg[6:0], r.flags[core_bitops_pkg::FLAG_C]}; // RL7
				sh_c = d_reg[7];
			end
			core_bitops_pkg::OP_SHIFT_DOWN_LOGICAL: begin
				d_sh = {1'b0, d_reg[7:1]}; // RL8
				sh_c = d_reg[0];
			end
			core_bitops_pkg::OP_ROTATE_DOWN_CARRY: begin
				d_sh = {r.flags[core_bitops_pkg::FLAG_C], d_reg[7:1]}; // RL8
				sh_c = d_reg[0];
			end
			core_bitops_pkg::OP_SHIFT_DOWN_SIGNED: begin
				d_sh = {d_reg[7], d_reg[7:1]}; // RL8
				sh_c = d_reg[0];
			end
			default: begin
				d_sh = d_reg;
				sh_c = r.flags[core_bitops_pkg::FLAG_C];
			end
		endcase

		// execution: the effect lands at the end of the last cycle
		case (r.st)
			st_idle: ;
			st_run: begin
				if (r.cnt != 3'h0) begin
					next_r.cnt = r.cnt - 3'h1;
				end else begin
					next_r.st = st_idle;
					case (r.op)
						core_bitops_pkg::OP_IO_READ:
							next_r.gpr[r.rsel[GAW-1:0]] = r.io[r.asel[IAW-1:0]]; // RL1 RL17
						core_bitops_pkg::OP_IO_WRITE:
							next_r.io[r.asel[IAW-1:0]] = d_reg; // RL1 RL17
						core_bitops_pkg::OP_PUSH: begin
							next_r.ram[r.sptr[RAW-1:0]] = d_reg; // RL2
							next_r.sptr = r.sptr - 16'h0001;
						end
						core_bitops_pkg::OP_POP: begin
							next_r.gpr[r.rsel[GAW-1:0]] = r.ram[pop_idx]; // RL3
							next_r.sptr = r.sptr + 16'h0001;
						end
						core_bitops_pkg::OP_ATOMIC_EXCHANGE: begin
							next_r.gpr[r.rsel[GAW-1:0]] = d_ram; // RL4
							next_r.ram[z_idx] = d_reg;
						end
						core_bitops_pkg::OP_ATOMIC_LOAD_OR: begin
							next_r.gpr[r.rsel[GAW-1:0]] = d_ram; // RL4
							next_r.ram[z_idx] = d_reg | d_ram;
						end
						core_bitops_pkg::OP_ATOMIC_LOAD_ANDNOT: begin
							next_r.gpr[r.rsel[GAW-1:0]] = d_ram; // RL5
							next_r.ram[z_idx] = ~d_reg & d_ram;
						end
						core_bitops_pkg::OP_ATOMIC_LOAD_XOR: begin
							next_r.gpr[r.rsel[GAW-1:0]] = d_ram; // RL6
							next_r.ram[z_idx] = d_reg ^ d_ram;
						end
						core_bitops_pkg::OP_SHIFT_UP_LOGICAL,
						core_bitops_pkg::OP_ROTATE_UP_CARRY,
						core_bitops_pkg::OP_SHIFT_DOWN_LOGICAL,
						core_bitops_pkg::OP_ROTATE_DOWN_CARRY,
						core_bitops_pkg::OP_SHIFT_DOWN_SIGNED: begin
							next_r.gpr[r.rsel[GAW-1:0]] = d_sh;
							next_r.flags[core_bitops_pkg::FLAG_C] = sh_c; // RL7 RL8
							next_r.flags[core_bitops_pkg::FLAG_Z] = (d_sh == 8'h00); // RL7 RL8
							next_r.flags[core_bitops_pkg::FLAG_N] = d_sh[7]; // RL7 RL8
							next_r.flags[core_bitops_pkg::FLAG_V] = d_sh[7] ^ sh_c; // RL7 RL8
							if (r.op == core_bitops_pkg::OP_SHIFT_UP_LOGICAL
									|| r.op == core_bitops_pkg::OP_ROTATE_UP_CARRY) begin
								next_r.flags[core_bitops_pkg::FLAG_H] = d_reg[3]; // RL7
							end
						end
						core_bitops_pkg::OP_NIBBLE_SWAP:
							next_r.gpr[r.rsel[GAW-1:0]] = {d_reg[3:0], d_reg[7:4]}; // RL17
						core_bitops_pkg::OP_STATUS_FLAG_ONE:
							next_r.flags[r.bsel] = 1'b1; // RL12 RL13 RL14
						core_bitops_pkg::OP_STATUS_FLAG_ZERO:
							next_r.flags[r.bsel] = 1'b0; // RL12 RL13 RL14
						core_bitops_pkg::OP_IO_BIT_ONE:
							next_r.io[r.asel[IAW-1:0]][r.bsel] = 1'b1; // RL9
						core_bitops_pkg::OP_IO_BIT_ZERO:
							next_r.io[r.asel[IAW-1:0]][r.bsel] = 1'b0; // RL9
						core_bitops_pkg::OP_REG_BIT_TO_T:
							next_r.flags[core_bitops_pkg::FLAG_T] = d_reg[r.bsel]; // RL10
						core_bitops_pkg::OP_T_TO_REG_BIT:
							next_r.gpr[r.rsel[GAW-1:0]][r.bsel] = r.flags[core_bitops_pkg::FLAG_T]; // RL11
						default: ;
					endcase
				end
			end
			default:
				next_r.st = st_idle;
		endcase

		// ports are driven from flops, so their next values are decided here
		next_r.wreq = !next_r.ack;
		next_r.run  = (next_r.st == st_run);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r       <= '0;
			r.sptr  <= SP_RESET;
			r.flags <= core_bitops_pkg::STATUS_RESET;
			r.wreq  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign readdata        = r.rdata;
	assign waitrequest     = r.wreq;
	assign busy            = r.run;
	assign status_register = r.flags;

endmodule

// file: core_bitops_props.sv
// assertions on bus handshake, command timing and flag effects of the bit unit
// assumes it is bound to core_bitops and sees only its ports
`timescale 1ns/100ps
module core_bitops_props (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [5:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        busy,
	input wire logic [7:0]  status_register
);
	logic       go;
	logic [4:0] op;
	logic [7:0] sel;
	assign go = write && !waitrequest && address == core_bitops_pkg::OFS_COMMAND && byteenable[0];
	assign op = writedata[4:0];
	assign sel = 8'h01 << writedata[18:16];
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("waitrequest low twice");
	a_busy_holds_bus: assert property (busy |-> waitrequest) else $error("bus answered while busy");
	a_io_one_cycle: assert property (go && (op == core_bitops_pkg::OP_IO_READ || op == core_bitops_pkg::OP_IO_WRITE)
		|=> busy ##1 (!busy && status_register == $past(status_register, 2))) else $error("io transfer timing");
	a_push_cycles: assert property (go && op == core_bitops_pkg::OP_PUSH |=> busy[*2] ##1 !busy)
		else $error("push cycle count");
	a_pop_cycles: assert property (go && op == core_bitops_pkg::OP_POP |=> busy[*3] ##1 !busy)
		else $error("pop cycle count");
	a_atomic_cycles: assert property (go && op >= core_bitops_pkg::OP_ATOMIC_EXCHANGE
		&& op <= core_bitops_pkg::OP_ATOMIC_LOAD_XOR
		|=> busy[*3] ##1 (!busy && status_register == $past(status_register, 4))) else $error("atomic timing");
	a_shift_one: assert property (go && op >= core_bitops_pkg::OP_SHIFT_UP_LOGICAL
		&& op <= core_bitops_pkg::OP_SHIFT_DOWN_SIGNED |=> busy ##1 !busy) else $error("shift cycle count");
	a_iobit_one: assert property (go && (op == core_bitops_pkg::OP_IO_BIT_ONE || op == core_bitops_pkg::OP_IO_BIT_ZERO)
		|=> busy ##1 (!busy && status_register == $past(status_register, 2))) else $error("io bit timing");
	a_tstore_only: assert property (go && op == core_bitops_pkg::OP_REG_BIT_TO_T
		|=> ##1 ((status_register ^ $past(status_register, 2)) & 8'hBF) == 8'h00) else $error("bit store flags");
	a_tload_flags: assert property (go && op == core_bitops_pkg::OP_T_TO_REG_BIT
		|=> ##1 status_register == $past(status_register, 2)) else $error("bit load flags");
	a_flag_one: assert property (go && op == core_bitops_pkg::OP_STATUS_FLAG_ONE
		|=> ##1 status_register == ($past(status_register, 2) | $past(sel, 2))) else $error("flag set");
	a_flag_zero: assert property (go && op == core_bitops_pkg::OP_STATUS_FLAG_ZERO
		|=> ##1 status_register == ($past(status_register, 2) & ~$past(sel, 2))) else $error("flag clear");
endmodule
bind core_bitops core_bitops_props props (.clock(clock), .nrst(nrst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .busy(busy), .status_register(status_register));

// file: bus_master.sv
// software side of the register bus: an Avalon-MM master driven by bench calls
// assumes one clock; each call waits for waitrequest low under a bounded count
`timescale 1ns/100ps
module bus_master (
	input  wire logic        clock,
	input  wire logic        waitrequest,
	input  wire logic [31:0] readdata,
	output logic      [5:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable
);
	initial begin
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
	end
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q, output bit ok);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		read <= !w;
		write <= w;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		q = readdata;
		ok = (waitrequest === 1'b0);
		read <= 1'b0;
		write <= 1'b0;
		// released data lines must not keep the last value
		writedata <= ~d;
	endtask
endmodule

// file: testbench.sv
// self-checking bench of the bit and transfer unit
// assumes bus_master drives the register bus and core_bitops_props is bound
`timescale 1ns/100ps
module testbench;
	logic        clock;
	logic        nrst;
	logic [5:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        busy;
	logic [7:0]  status_register;
	int          mismatches;
	int          checks_done;
	logic [31:0] q;
	bit          ok;
	core_bitops dut (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.busy(busy), .status_register(status_register));
	bus_master master (.clock(clock), .waitrequest(waitrequest), .readdata(readdata), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
	always #25 clock = ~clock;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xf(input logic w, input logic [5:0] a, input logic [31:0] d);
		master.xfer(w, a, d, q, ok);
		if (!ok) begin
			mismatches++;
			wrap_up();
		end
	endtask
	task automatic sl(input logic [1:0] s, input logic [7:0] i, input logic [7:0] v);
		xf(1'b1, core_bitops_pkg::OFS_ACCESS_ADDR, {22'h0, s, i});
		xf(1'b1, core_bitops_pkg::OFS_ACCESS_DATA, {24'h0, v});
	endtask
	task automatic gl(input logic [1:0] s, input logic [7:0] i, input logic [7:0] e);
		xf(1'b1, core_bitops_pkg::OFS_ACCESS_ADDR, {22'h0, s, i});
		xf(1'b0, core_bitops_pkg::OFS_ACCESS_DATA, 32'h0);
		chk({24'h0, q[7:0]}, {24'h0, e});
	endtask
	task automatic st(input logic [7:0] v);
		xf(1'b1, core_bitops_pkg::OFS_STATUS_REG, {24'h0, v});
	endtask
	// status seen both over the bus and on the port
	task automatic gs(input logic [7:0] e);
		xf(1'b0, core_bitops_pkg::OFS_STATUS_REG, 32'h0);
		chk({16'h0, q[7:0], status_register}, {16'h0, e, e});
	endtask
	task automatic cmd(input logic [4:0] op, input logic [4:0] r, input logic [2:0] b, input logic [5:0] io);
		xf(1'b1, core_bitops_pkg::OFS_COMMAND, {2'h0, io, 5'h0, b, 3'h0, r, 3'h0, op});
	endtask
	task automatic t_reset;
		gs(8'h00);
		xf(1'b0, core_bitops_pkg::OFS_STACK_PTR, 32'h0);
		chk(q, 32'h0000_00FF);
		xf(1'b0, 6'h1C, 32'h0);
		chk(q, 32'h0);
		xf(1'b0, core_bitops_pkg::OFS_EXEC_INFO, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic t_io_stack;
		sl(core_bitops_pkg::SPACE_GPR, 8'h03, 8'hA5);
		st(8'h5A);
		cmd(core_bitops_pkg::OP_IO_WRITE, 5'h03, 3'h0, 6'h0A);
		@(negedge clock);
		chk({31'h0, busy}, 32'h1);
		@(negedge clock);
		chk({31'h0, busy}, 32'h0);
		gl(core_bitops_pkg::SPACE_IO, 8'h0A, 8'hA5);
		cmd(core_bitops_pkg::OP_IO_READ, 5'h04, 3'h0, 6'h0A);
		gl(core_bitops_pkg::SPACE_GPR, 8'h04, 8'hA5);
		cmd(core_bitops_pkg::OP_PUSH, 5'h03, 3'h0, 6'h00);
		gl(core_bitops_pkg::SPACE_RAM, 8'hFF, 8'hA5);
		sl(core_bitops_pkg::SPACE_GPR, 8'h05, 8'h00);
		cmd(core_bitops_pkg::OP_POP, 5'h05, 3'h0, 6'h00);
		gl(core_bitops_pkg::SPACE_GPR, 8'h05, 8'hA5);
		xf(1'b0, core_bitops_pkg::OFS_STACK_PTR, 32'h0);
		chk(q, 32'h0000_00FF);
		xf(1'b0, core_bitops_pkg::OFS_EXEC_INFO, 32'h0);
		chk(q, {28'h0, 3'(core_bitops_pkg::CYC_TWO + core_bitops_pkg::CYC_SRAM_EXTRA), 1'b0});
		gs(8'h5A);
	endtask
	task automatic t_atomic;
		logic [7:0] e [4] = '{8'h0F, 8'h3F, 8'h30, 8'h33};
		xf(1'b1, core_bitops_pkg::OFS_Z_POINTER, 32'h20);
		for (int i = 0; i < 4; i++) begin
			sl(core_bitops_pkg::SPACE_RAM, 8'h20, 8'h3C);
			sl(core_bitops_pkg::SPACE_GPR, 8'h06, 8'h0F);
			cmd(5'(core_bitops_pkg::OP_ATOMIC_EXCHANGE + i), 5'h06, 3'h0, 6'h00);
			gl(core_bitops_pkg::SPACE_RAM, 8'h20, e[i]);
			gl(core_bitops_pkg::SPACE_GPR, 8'h06, 8'h3C);
		end
		gs(8'h5A);
	endtask
	task automatic t_shift;
		logic [7:0] v;
		logic [7:0] r;
		logic       c;
		logic       nc;
		for (int k = 0; k < 10; k++) begin
			c = k[0];
			v = c ? 8'h81 : 8'h01;
			sl(core_bitops_pkg::SPACE_GPR, 8'h09, v);
			st(8'hA0 | {7'h0, c});
			case (k / 2)
				0: begin r = {v[6:0], 1'b0}; nc = v[7]; end
				1: begin r = {1'b0, v[7:1]}; nc = v[0]; end
				2: begin r = {v[6:0], c}; nc = v[7]; end
				3: begin r = {c, v[7:1]}; nc = v[0]; end
				default: begin r = {v[7], v[7:1]}; nc = v[0]; end
			endcase
			cmd(5'(core_bitops_pkg::OP_SHIFT_UP_LOGICAL + k / 2), 5'h09, 3'h0, 6'h00);
			gl(core_bitops_pkg::SPACE_GPR, 8'h09, r);
			gs({2'b10, (k / 2 == 0 || k / 2 == 2) ? v[3] : 1'b1, 1'b0, r[7] ^ nc, r[7], r == 8'h00, nc});
		end
	endtask
	task automatic t_flags;
		for (int b = 0; b < 8; b++) begin
			st(8'h00);
			cmd(core_bitops_pkg::OP_STATUS_FLAG_ONE, 5'h00, 3'(b), 6'h00);
			gs(8'h01 << b);
			st(8'hFF);
			cmd(core_bitops_pkg::OP_STATUS_FLAG_ZERO, 5'h00, 3'(b), 6'h00);
			gs(~(8'h01 << b));
		end
	endtask
	task automatic t_bits;
		st(8'h5A);
		sl(core_bitops_pkg::SPACE_IO, 8'h0C, 8'h00);
		cmd(core_bitops_pkg::OP_IO_BIT_ONE, 5'h00, 3'h5, 6'h0C);
		gl(core_bitops_pkg::SPACE_IO, 8'h0C, 8'h20);
		sl(core_bitops_pkg::SPACE_IO, 8'h0C, 8'hFF);
		cmd(core_bitops_pkg::OP_IO_BIT_ZERO, 5'h00, 3'h2, 6'h0C);
		gl(core_bitops_pkg::SPACE_IO, 8'h0C, 8'hFB);
		gs(8'h5A);
		st(8'h00);
		sl(core_bitops_pkg::SPACE_GPR, 8'h07, 8'h10);
		cmd(core_bitops_pkg::OP_REG_BIT_TO_T, 5'h07, 3'h4, 6'h00);
		gs(8'h40);
		sl(core_bitops_pkg::SPACE_GPR, 8'h08, 8'h00);
		cmd(core_bitops_pkg::OP_T_TO_REG_BIT, 5'h08, 3'h2, 6'h00);
		gl(core_bitops_pkg::SPACE_GPR, 8'h08, 8'h04);
		gs(8'h40);
	endtask
	task automatic t_swap;
		st(8'h5A);
		sl(core_bitops_pkg::SPACE_GPR, 8'h0A, 8'h3C);
		cmd(core_bitops_pkg::OP_NIBBLE_SWAP, 5'h0A, 3'h0, 6'h00);
		gl(core_bitops_pkg::SPACE_GPR, 8'h0A, 8'hC3);
		gs(8'h5A);
		xf(1'b0, core_bitops_pkg::OFS_EXEC_INFO, 32'h0);
		chk(q, {28'h0, core_bitops_pkg::CYC_ONE, 1'b0});
	endtask
	// reset pulse while no command runs: all state returns to its reset values
	task automatic t_midreset;
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		gl(core_bitops_pkg::SPACE_GPR, 8'h0A, 8'h00);
	endtask
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		mismatches = 0;
		checks_done = 0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_io_stack();
		t_atomic();
		t_shift();
		t_flags();
		t_bits();
		t_swap();
		t_midreset();
		wrap_up();
	end
endmodule
